//--- design/wr_cmd_pkg.sv
/*
  constants shared by the write command handler: function codes, header
  layout, output counts and reset values.
  assumes a byte stream of complete Modbus/TCP frames from the link side.
*/
package wr_cmd_pkg;
  // ----------------------------------------
  // function and exception codes
  // ----------------------------------------
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  localparam logic [7:0] EXC_FLAG    = 8'h80;
  localparam logic [7:0] EXC_FUNC    = 8'h01;
  localparam logic [7:0] EXC_ADDR    = 8'h02;
  localparam logic [7:0] EXC_VALUE   = 8'h03;
  // ----------------------------------------
  // frame layout (byte positions, frame and reply lengths)
  // ----------------------------------------
  localparam int         POS_LEN_LO  = 5;
  localparam int         POS_FC      = 7;
  localparam int         POS_ADR_HI  = 8;
  localparam int         POS_ADR_LO  = 9;
  localparam int         POS_QTY_HI  = 10;
  localparam int         POS_QTY_LO  = 11;
  localparam int         POS_BCOUNT  = 12;
  localparam int         POS_DATA    = 13;
  localparam int         FRAME_MAX   = 64;
  localparam logic [7:0] LEN_ECHO    = 8'h06;
  localparam logic [7:0] LEN_EXC     = 8'h03;
  localparam int         RESP_FULL   = 12;
  localparam int         RESP_EXC    = 9;
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  localparam int          NUM_AO     = 2;
  localparam int          NUM_DO     = 8;
  localparam logic [15:0] AO_RESET   = 16'h0000;
  localparam logic [7:0]  DO_RESET   = 8'h00;
  typedef logic [5:0] idx_t;
endpackage

//--- design/coil_merge.sv
/*
  merges packed coil bits into the digital output image.
  assumes start and quantity already checked against the output count.
*/
`timescale 1ns/100ps
module coil_merge
(
  input  wire logic [7:0] cur,
  input  wire logic [7:0] packed_bits,
  input  wire logic [7:0] start,
  input  wire logic [7:0] qty,
  output logic      [7:0] merged
);
  // ----------------------------------------
  // merge
  // ----------------------------------------
  always_comb
  begin
    merged = cur;
    for (int i = 0; i < wr_cmd_pkg::NUM_DO; i++)
    begin
      // bit k of the data lands on output start+k, lsb first
      if (i >= int'(start) && i < int'(start) + int'(qty))
        merged[i] = packed_bits[i - int'(start)];
    end
  end
endmodule

//--- design/wr_cmd.sv
/*
  write command handler: takes a Modbus/TCP request byte stream, applies
  single register, multiple coil and multiple register writes, streams
  the reply.
  assumes rx_last marks the final byte of a frame; tx_ready from the link.
*/
`timescale 1ns/100ps
module wr_cmd
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic [15:0]      analog_output_zero,
  output logic [15:0]      analog_output_one,
  output logic [7:0]       digital_outputs
);
  typedef enum logic [3:0]
  {
    ST_RX   = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_TX   = 4'b0100,
    ST_DRAIN = 4'b1000
  } state_e;

  state_e      state;
  state_e      next_state;
  logic [7:0]  frame [wr_cmd_pkg::FRAME_MAX];
  wr_cmd_pkg::idx_t cnt;
  wr_cmd_pkg::idx_t next_cnt;
  wr_cmd_pkg::idx_t tx_len;
  wr_cmd_pkg::idx_t next_tx_len;
  logic [7:0]  exc_code;
  logic [7:0]  next_exc_code;
  logic [15:0] ao [wr_cmd_pkg::NUM_AO];
  logic [15:0] next_ao [wr_cmd_pkg::NUM_AO];
  logic [7:0]  dout;
  logic [7:0]  next_dout;
  logic [7:0]  coil_img;
  logic [7:0]  tx_byte;
  logic [7:0]  next_tx_byte;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] word_at(input int pos);
    // high byte first on the wire
    word_at = {frame[pos], frame[pos + 1]};
  endfunction

  function automatic logic range_ok(input logic [15:0] start, input logic [15:0] qty,
                                    input int lim);
    range_ok = (qty != 16'h0000) && (32'(start) + 32'(qty) <= 32'(lim));
  endfunction

  logic [7:0]  fc;
  logic [15:0] adr;
  logic [15:0] qty;
  assign fc  = frame[wr_cmd_pkg::POS_FC];
  assign adr = word_at(wr_cmd_pkg::POS_ADR_HI);
  assign qty = word_at(wr_cmd_pkg::POS_QTY_HI);

  coil_merge u_merge
  (
    .cur         (dout),
    .packed_bits (frame[wr_cmd_pkg::POS_DATA]),
    .start       (adr[7:0]),
    .qty         (qty[7:0]),
    .merged      (coil_img)
  );

  // ----------------------------------------
  // frame store
  // ----------------------------------------
  // only one frame held: the receiver stalls until the reply is out
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < wr_cmd_pkg::FRAME_MAX; i++)
        frame[i] <= 8'h00;
    end
    else if (clk_en && state == ST_RX && rx_valid && int'(cnt) < wr_cmd_pkg::FRAME_MAX)
      frame[cnt] <= rx_data;
  end

  // ----------------------------------------
  // control and outputs
  // ----------------------------------------
  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_tx_len   = tx_len;
    next_exc_code = exc_code;
    next_ao       = ao;
    next_dout     = dout;
    next_tx_byte  = tx_byte;
    case (state)
      ST_RX:
      begin
        if (rx_valid)
        begin
          next_cnt = cnt + 6'd1;
          if (rx_last)
          begin
            next_state = ST_EXEC;
            next_cnt   = '0;
          end
          else if (int'(cnt) == wr_cmd_pkg::FRAME_MAX - 1)
          begin
            next_state = ST_DRAIN;
            next_cnt   = '0;
          end
        end
      end
      ST_DRAIN:
      begin
        // oversize frame is thrown away without a reply
        if (rx_valid && rx_last)
          next_state = ST_RX;
      end
      ST_EXEC:
      begin
        next_state    = ST_TX;
        next_exc_code = 8'h00;
        next_tx_len   = 6'(wr_cmd_pkg::RESP_FULL);
        if (fc == wr_cmd_pkg::FC_WR_REG)
        begin
          // address zero is the first analog output
          if (range_ok(adr, 16'h0001, wr_cmd_pkg::NUM_AO))
            next_ao[adr[0]] = word_at(wr_cmd_pkg::POS_QTY_HI);
          else
            next_exc_code = wr_cmd_pkg::EXC_ADDR;
        end
        else if (fc == wr_cmd_pkg::FC_WR_COILS)
        begin
          if (frame[wr_cmd_pkg::POS_BCOUNT] != 8'((qty + 16'd7) >> 3) || qty == 16'h0000)
            next_exc_code = wr_cmd_pkg::EXC_VALUE;
          else if (!range_ok(adr, qty, wr_cmd_pkg::NUM_DO))
            next_exc_code = wr_cmd_pkg::EXC_ADDR;
          else
            next_dout = coil_img;
        end
        else if (fc == wr_cmd_pkg::FC_WR_REGS)
        begin
          if (frame[wr_cmd_pkg::POS_BCOUNT] != 8'(qty << 1) || qty == 16'h0000)
            next_exc_code = wr_cmd_pkg::EXC_VALUE;
          else if (!range_ok(adr, qty, wr_cmd_pkg::NUM_AO))
            next_exc_code = wr_cmd_pkg::EXC_ADDR;
          else
          begin
            for (int i = 0; i < wr_cmd_pkg::NUM_AO; i++)
            begin
              if (i >= int'(adr) && i < int'(adr) + int'(qty))
                next_ao[i] = word_at(wr_cmd_pkg::POS_DATA + 2 * (i - int'(adr)));
            end
          end
        end
        else
          next_exc_code = wr_cmd_pkg::EXC_FUNC;
        if (next_exc_code != 8'h00)
          next_tx_len = 6'(wr_cmd_pkg::RESP_EXC);
        next_cnt     = '0;
        next_tx_byte = frame[0];
      end
      ST_TX:
      begin
        if (tx_ready)
        begin
          next_cnt = cnt + 6'd1;
          if (cnt + 6'd1 == tx_len)
          begin
            next_state = ST_RX;
            next_cnt   = '0;
          end
          else
          begin
            // ids copied, length patched
            if (int'(cnt) + 1 == wr_cmd_pkg::POS_LEN_LO)
              next_tx_byte = (exc_code != 8'h00) ? wr_cmd_pkg::LEN_EXC : wr_cmd_pkg::LEN_ECHO;
            else if (int'(cnt) + 1 == wr_cmd_pkg::POS_FC && exc_code != 8'h00)
              next_tx_byte = fc | wr_cmd_pkg::EXC_FLAG;
            else if (int'(cnt) + 1 == wr_cmd_pkg::POS_ADR_HI && exc_code != 8'h00)
              next_tx_byte = exc_code;
            else
              next_tx_byte = frame[cnt + 6'd1];
          end
        end
      end
      default:
        next_state = ST_RX;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_RX;
      cnt      <= '0;
      tx_len   <= '0;
      exc_code <= 8'h00;
      ao[0]    <= wr_cmd_pkg::AO_RESET;
      ao[1]    <= wr_cmd_pkg::AO_RESET;
      dout     <= wr_cmd_pkg::DO_RESET;
      tx_byte  <= 8'h00;
    end
    else if (clk_en)
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      tx_len   <= next_tx_len;
      exc_code <= next_exc_code;
      ao       <= next_ao;
      dout     <= next_dout;
      tx_byte  <= next_tx_byte;
    end
  end

  assign rx_ready           = clk_en && (state == ST_RX || state == ST_DRAIN);
  assign tx_valid           = clk_en && state == ST_TX;
  assign tx_last            = tx_valid && (cnt + 6'd1 == tx_len);
  assign tx_data            = tx_byte;
  assign analog_output_zero = ao[0];
  assign analog_output_one  = ao[1];
  assign digital_outputs    = dout;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence exec_good_reg;
    state == ST_EXEC && fc == wr_cmd_pkg::FC_WR_REG && adr < 16'd2;
  endsequence

  reply_after_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (exec_good_reg and clk_en) |=> state == ST_TX && ao[$past(adr[0])] == $past(qty))
    else $error("single register not written before reply");

  reg_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && fc == wr_cmd_pkg::FC_WR_REG && adr >= 16'd2 |=> exc_code == 8'h02)
    else $error("out of range register not refused");

  bad_func_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && fc != 8'h06 && fc != 8'h0F && fc != 8'h10
    |=> exc_code == 8'h01 && tx_len == 6'd9 && $stable(dout))
    else $error("unknown function not refused");

  exc_keeps_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_TX && exc_code != 8'h00 |-> $stable(dout) && $stable(analog_output_zero))
    else $error("outputs changed on exception");

  reply_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && exc_code == 8'h00 ##1 exc_code == 8'h00 |-> tx_len == 6'd12)
    else $error("normal reply length wrong");

  len_field_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_valid && cnt == 6'd5 |-> tx_data == ((exc_code != 8'h00) ? 8'h03 : 8'h06))
    else $error("header length wrong");

  id_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_valid && cnt == 6'd0 |-> tx_data == frame[0])
    else $error("transaction id not copied");

  last_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tx_last && tx_ready |=> state == ST_RX)
    else $error("reply did not end after last byte");

  coil_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && fc == 8'h0F && adr == 16'd0 && qty == 16'd8
    && frame[12] == 8'h01 |=> dout == $past(frame[13]))
    else $error("coil bits not applied");

  regs_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && fc == wr_cmd_pkg::FC_WR_REGS && adr == 16'd0 && qty == 16'd2
    && frame[12] == 8'h04 |=> analog_output_zero == $past({frame[13], frame[14]})
    && analog_output_one == $past({frame[15], frame[16]}))
    else $error("register words not high byte first");

  coil_single_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state == ST_EXEC && clk_en && fc == wr_cmd_pkg::FC_WR_COILS && adr == 16'd0 && qty == 16'd1
    && frame[12] == 8'h01 |=> dout[0] == $past(frame[13][0]) && dout[7:1] == $past(dout[7:1]))
    else $error("single coil not applied alone");
endmodule

//--- sim/client_model.sv
/*
  client model: sends one request frame per go pulse, then collects the
  reply until its last byte. assumes the byte handshake of wr_cmd, taken
  on the rising edge of clk_sys.
*/
`timescale 1ns/100ps
module client_model
(
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [7:0] req [64],
  input  wire logic [6:0] req_len,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            tx_ready,
  output logic            done,
  output logic [7:0]      rsp [64],
  output logic [6:0]      rsp_len
);
  int   i;
  logic fin;
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    done     = 1'b1;
    rsp_len  = 7'h00;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        done <= 1'b0;
        for (i = 0; i < req_len; i++)
        begin
          rx_valid <= 1'b1;
          rx_data  <= req[i];
          rx_last  <= (i == req_len - 1);
          // ready judged mid-cycle, where it has settled
          do @(negedge clk_sys); while (!rx_ready);
          @(posedge clk_sys);
        end
        // released line shows the inverse, never a stale byte
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~rx_data;
        rsp_len = 7'h00;
        fin = 1'b0;
        while (!fin)
        begin
          tx_ready <= slow ? ~tx_ready : 1'b1;
          @(negedge clk_sys);
          if (tx_valid && tx_ready)
          begin
            rsp[rsp_len] = tx_data;
            rsp_len = rsp_len + 7'h01;
            fin = tx_last;
          end
          @(posedge clk_sys);
        end
        tx_ready <= 1'b0;
        done     <= 1'b1;
      end
    end
  end
endmodule

//--- sim/tb.sv
/*
  testbench for wr_cmd: random and corner write frames; reply bytes and
  output image compared with values worked out here.
  assumes client_model on the request and reply side.
*/
`timescale 1ns/100ps
module tb;
  logic        clk_sys, rst_n, go, slow, done;
  logic        clk_en = 1'b1;
  logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data, digital_outputs, dout;
  logic [15:0] analog_output_zero, analog_output_one;
  logic [7:0]  req [64];
  logic [7:0]  rsp [64];
  logic [6:0]  req_len, rsp_len;
  logic [15:0] ao [2];
  logic [39:0] snap;
  int          num_errors, comparisons, t, s, q;
  int          cycles = 0;
  int          seed = 32'h59FBB353;

  wr_cmd i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .analog_output_zero(analog_output_zero),
    .analog_output_one(analog_output_one), .digital_outputs(digital_outputs));
  client_model i_client (.clk_sys(clk_sys), .go(go), .slow(slow), .req(req), .req_len(req_len),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .tx_ready(tx_ready), .done(done), .rsp(rsp), .rsp_len(rsp_len));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // random clock enable, timeout
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    clk_en <= ($random(seed) % 4) != 0;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  // outputs seen while the reply is out; they may not move during it
  always @(negedge clk_sys)
    if (tx_valid)
      snap <= {analog_output_zero, analog_output_one, digital_outputs};

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_outs(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_byte(input int k, input logic [7:0] fc, input logic [7:0] exc);
    if (k == 5)
      return (exc != 8'h00) ? wr_cmd_pkg::LEN_EXC : wr_cmd_pkg::LEN_ECHO;
    if (exc != 8'h00 && k == 7)
      return fc | wr_cmd_pkg::EXC_FLAG;
    if (exc != 8'h00 && k == 8)
      return exc;
    return req[k];
  endfunction

  // ----------------------------------------
  // one frame: build, predict, send, compare
  // ----------------------------------------
  task automatic run(input logic [7:0] fc, input logic [15:0] adr, input logic [15:0] qty,
                     input int nb, input logic [7:0] bc, input logic [7:0] exc);
    int k;
    @(negedge clk_sys);
    for (k = 0; k < 64; k++)
      req[k] = 8'($random(seed));
    {req[2], req[3], req[4]} = 24'h000000;
    req[5] = 8'(nb < 0 ? 6 : 7 + nb);
    req_len = 7'(req[5]) + 7'h06;
    req[7] = fc;
    {req[8], req[9], req[10], req[11]} = {adr, qty};
    if (nb >= 0)
      req[12] = bc;
    if (exc == 8'h00)
      case (fc)
        wr_cmd_pkg::FC_WR_REG: ao[adr[0]] = qty;
        wr_cmd_pkg::FC_WR_COILS: for (k = 0; k < qty; k++) dout[adr + k] = req[13 + k / 8][k % 8];
        default: for (k = 0; k < qty; k++) ao[adr[0] + k] = {req[13 + 2 * k], req[14 + 2 * k]};
      endcase
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (!done) @(posedge clk_sys);
    check_byte({1'b0, rsp_len}, 8'(exc == 8'h00 ? wr_cmd_pkg::RESP_FULL : wr_cmd_pkg::RESP_EXC));
    for (k = 0; k < rsp_len; k++)
      check_byte(rsp[k], exp_byte(k, fc, exc));
    check_outs(snap, {ao[0], ao[1], dout});
    $display("test fc %h exc %h done", fc, exc);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    num_errors = 0;
    comparisons = 0;
    {rst_n, go, slow, req_len} = {3'b000, 7'h00};
    {ao[0], ao[1], dout} = {wr_cmd_pkg::AO_RESET, wr_cmd_pkg::AO_RESET, wr_cmd_pkg::DO_RESET};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check_outs({analog_output_zero, analog_output_one, digital_outputs}, {ao[0], ao[1], dout});
    run(wr_cmd_pkg::FC_WR_REG, 16'h0001, 16'h55FF, -1, 8'h00, 8'h00);
    run(wr_cmd_pkg::FC_WR_REG, 16'h0000, 16'hA00B, -1, 8'h00, 8'h00);
    run(wr_cmd_pkg::FC_WR_REGS, 16'h0000, 16'h0002, 4, 8'h04, 8'h00);
    run(wr_cmd_pkg::FC_WR_COILS, 16'h0000, 16'h0008, 1, 8'h01, 8'h00);
    run(wr_cmd_pkg::FC_WR_COILS, 16'h0000, 16'h0001, 1, 8'h01, 8'h00);
    for (t = 0; t < 16; t++)
    begin
      @(negedge clk_sys);
      slow = t[0];
      s = {$random(seed)} % 8;
      q = 1 + {$random(seed)} % (8 - s);
      run(wr_cmd_pkg::FC_WR_COILS, 16'(s), 16'(q), 1, 8'h01, 8'h00);
      s = {$random(seed)} % 2;
      q = 1 + {$random(seed)} % (2 - s);
      run(wr_cmd_pkg::FC_WR_REGS, 16'(s), 16'(q), 2 * q, 8'(2 * q), 8'h00);
    end
    run(8'h03, 16'h0000, 16'h0002, -1, 8'h00, wr_cmd_pkg::EXC_FUNC);
    run(wr_cmd_pkg::FC_WR_COILS, 16'h0000, 16'h0000, 0, 8'h00, wr_cmd_pkg::EXC_VALUE);
    run(wr_cmd_pkg::FC_WR_COILS, 16'h0007, 16'h0002, 1, 8'h01, wr_cmd_pkg::EXC_ADDR);
    run(wr_cmd_pkg::FC_WR_REG, 16'h0002, 16'h1234, -1, 8'h00, wr_cmd_pkg::EXC_ADDR);
    run(wr_cmd_pkg::FC_WR_REGS, 16'h0000, 16'h0002, 4, 8'h03, wr_cmd_pkg::EXC_VALUE);
    run(wr_cmd_pkg::FC_WR_REGS, 16'h0001, 16'h0002, 4, 8'h04, wr_cmd_pkg::EXC_ADDR);
    report_and_stop();
  end
endmodule
